// ### dv/host_model.sv
// Behavioural host controller that reaches the block's registers.
`timescale 1ns/100ps
module host_model
    import liu_reg_pkg::*;
(
    input  wire logic       i_ref_clk,  // Master clock.
    input  wire logic [7:0] i_rd_data,  // Read answer byte.
    input  wire logic       i_rd_valid, // Read answer pulse.
    output host_req_type    o_host      // Request strobes.
);
    initial o_host = '0;

    // Idle lines show the inverse of their last value.
    task automatic go_idle();
        o_host = '{write: 1'b0, read: 1'b0, addr: ~o_host.addr,
                   data: ~o_host.data};
    endtask

    // One write, then a spare cycle.
    task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
        logic [7:0] val;
        val = data;
        if (addr >= ADDR_GLOBAL_CONFIG && addr <= ADDR_IRQ_EDGE_SELECT)
            val = data & (CTRL_MASK[addr - 5'h02] | 8'h04);
        o_host = '{write: 1'b1, read: 1'b0, addr: addr, data: val};
        @(posedge i_ref_clk);
        #1;
        go_idle();
        @(posedge i_ref_clk);
        #1;
    endtask

    // One read; the one-cycle answer is taken right after its edge.
    task automatic read_reg(input logic [4:0] addr, output logic [7:0] data,
                            output logic valid);
        o_host = '{write: 1'b0, read: 1'b1, addr: addr, data: 8'h00};
        @(posedge i_ref_clk);
        #1;
        valid = i_rd_valid;
        data  = i_rd_data;
        go_idle();
        @(posedge i_ref_clk);
        #1;
    endtask
endmodule

// ### dv/reset_and_register_map_assertions.sv
// Property checker for the reset and register map block.
`timescale 1ns/100ps
module reset_and_register_map_assertions
    import liu_reg_pkg::*;
#(
    parameter logic [7:0] SILICON_REVISION = 8'h3C  // Arbitrary value.
)
(
    input wire logic            i_ref_clk,       // Master clock.
    input wire logic            i_reset,         // Async reset, high.
    input wire logic            i_hw_reset_n,    // Reset pin, low active.
    input wire host_req_type    i_host,          // Host strobes.
    input wire logic [7:0]      o_rd_data,       // Read answer byte.
    input wire logic            o_rd_valid,      // Read answer pulse.
    input wire ctrl_bank_type   o_config,        // Control bank.
    input wire logic            o_line_standard, // Line standard.
    input wire logic            o_settling,      // Settle window.
    input wire logic            o_line_drive_en, // Driver enable.
    input wire logic            o_in_reset       // Reset in force.
);
    logic [1:0] soft_pipe;
    logic [4:0] pin_low;
    logic       cfg_at_default;

    // Accepted requests; the design shuts early after a trigger or pin.
    wire logic soft_wr  = i_host.write
        && (i_host.addr == ADDR_SOFT_RESET_TRIGGER);
    wire logic open_bus = !o_in_reset && (soft_pipe == 2'b00)
        && (pin_low < 5'd13);
    wire logic soft_acc = soft_wr && open_bus;
    wire logic wr_acc   = i_host.write && open_bus;
    wire logic rd_acc   = i_host.read && !i_host.write && open_bus;
    wire logic gc_wr    = wr_acc && (i_host.addr == ADDR_GLOBAL_CONFIG);

    // Bank at defaults, kept line-standard bit aside.
    always_comb
    begin
        cfg_at_default = (o_config[0][1:0] == 2'b00);
        for (int i = 1; i < CTRL_COUNT; i++)
        begin
            if (o_config[i] != CTRL_RESET[i])
            begin
                cfg_at_default = 1'b0;
            end
        end
    end

    // Trigger pipe and pin low-time count.
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            soft_pipe <= 2'b00;
            pin_low   <= 5'h00;
        end
        else
        begin
            soft_pipe <= {soft_pipe[0], soft_acc};
            pin_low   <= i_hw_reset_n ? 5'h00
                : ((pin_low == 5'h1F) ? pin_low : pin_low + 5'h01);
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    property p_soft_seq;
        soft_acc |-> ##3 o_in_reset [*8] ##1 !o_in_reset;
    endproperty
    a_soft_seq: assert property (p_soft_seq)
        else $error("soft reset length");

    property p_drv_off;
        o_in_reset |-> !o_line_drive_en;
    endproperty
    a_drv_off: assert property (p_drv_off)
        else $error("drivers on in reset");

    property p_cfg_default;
        $rose(o_in_reset) |=> cfg_at_default;
    endproperty
    a_cfg_default: assert property (p_cfg_default)
        else $error("bank not at defaults");

    property p_keep_std;
        soft_acc |-> ##1 $stable(o_line_standard) [*8];
    endproperty
    a_keep_std: assert property (p_keep_std)
        else $error("standard lost in soft reset");

    property p_rd_answer;
        rd_acc |=> o_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");

    property p_revision;
        rd_acc && (i_host.addr == ADDR_SILICON_REVISION)
            |=> o_rd_data == SILICON_REVISION;
    endproperty
    a_revision: assert property (p_revision)
        else $error("revision byte wrong");

    property p_trigger_blank;
        rd_acc && (i_host.addr == ADDR_SOFT_RESET_TRIGGER)
            |=> o_rd_data == 8'h00;
    endproperty
    a_trigger_blank: assert property (p_trigger_blank)
        else $error("trigger holds a value");

    property p_std_write;
        gc_wr |=> o_line_standard == $past(i_host.data[2]);
    endproperty
    a_std_write: assert property (p_std_write)
        else $error("standard write lost");

    property p_settle;
        gc_wr && (i_host.data[2] != o_line_standard) |=> o_settling;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle not opened");

    property p_hw_reset;
        pin_low >= 5'd14 |-> o_in_reset && !o_line_standard;
    endproperty
    a_hw_reset: assert property (p_hw_reset)
        else $error("pin reset not in force");

    // Main scenarios.
    c_soft: cover property (soft_acc);
    c_pin: cover property (pin_low == 5'd14);
    c_settle_end: cover property ($fell(o_settling));
    c_revision: cover property (rd_acc && i_host.addr == 5'h00);
endmodule

bind reset_and_register_map reset_and_register_map_assertions #(
    .SILICON_REVISION (SILICON_REVISION)
) u_chk (
    .i_ref_clk       (i_ref_clk),
    .i_reset         (i_reset),
    .i_hw_reset_n    (i_hw_reset_n),
    .i_host          (i_host),
    .o_rd_data       (o_rd_data),
    .o_rd_valid      (o_rd_valid),
    .o_config        (o_config),
    .o_line_standard (o_line_standard),
    .o_settling      (o_settling),
    .o_line_drive_en (o_line_drive_en),
    .o_in_reset      (o_in_reset)
);

// ### dv/reset_and_register_map_test.sv
// Self-checking testbench of the reset and register map block.
`timescale 1ns/100ps
module reset_and_register_map_test;
    import liu_reg_pkg::*;
    localparam int         SETTLE = 20;
    localparam logic [7:0] REV    = 8'h3C;  // Arbitrary value.
    localparam logic [7:0] ST_EXP [6] = '{8'h7F, 8'h20, 8'h7F, 8'hC3,
                                          8'hEF, 8'hBE};

    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic            pin_n = 1'b1;
    host_req_type    host_req;
    line_status_type status = {8'hFF, 8'hFF, 8'hFF, 8'hC3, 16'hBEEF};
    logic [7:0]      rd_data;
    logic            rd_valid;
    ctrl_bank_type   config_bank;
    logic            line_std;
    logic            settling;
    logic            drive_en;
    logic            in_reset;
    int              failures = 0;
    int              checks = 0;

    // The clock never stops, pin reset included.
    always #5 ref_clk = ~ref_clk;

    reset_and_register_map #(.SETTLE_COUNT(SETTLE), .SILICON_REVISION(REV))
    dut (
        .i_ref_clk       (ref_clk),
        .i_reset         (rst),
        .i_hw_reset_n    (pin_n),
        .i_host          (host_req),
        .i_status        (status),
        .o_rd_data       (rd_data),
        .o_rd_valid      (rd_valid),
        .o_config        (config_bank),
        .o_line_standard (line_std),
        .o_settling      (settling),
        .o_line_drive_en (drive_en),
        .o_in_reset      (in_reset)
    );

    host_model host (
        .i_ref_clk  (ref_clk),
        .i_rd_data  (rd_data),
        .i_rd_valid (rd_valid),
        .o_host     (host_req)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic rd_exp(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        host.read_reg(a, d, v);
        chk({7'h00, v}, 8'h01, "read answer");
        chk(d, e, "read data");
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Bounded wait for the reset flag to drop.
    task automatic wait_release();
        for (int n = 0; n < 40 && in_reset !== 1'b0; n++)
            tick(1);
        chk(in_reset, 1'b0, "reset released");
    endtask

    task automatic t_defaults();
        chk(drive_en, 1'b0, "drivers off");
        chk(line_std, 1'b0, "E1 default");
        rd_exp(ADDR_SILICON_REVISION, REV);
        rd_exp(ADDR_SOFT_RESET_TRIGGER, 8'h00);
        rd_exp(5'h1D, 8'h00);
        for (int i = 0; i < CTRL_COUNT; i++)
            rd_exp(5'(i + 2), CTRL_RESET[i]);
    endtask

    task automatic t_map();
        for (int i = 1; i < CTRL_COUNT; i++)
            host.write_reg(5'(i + 2), 8'h5A ^ 8'(i));
        for (int i = 1; i < CTRL_COUNT; i++)
            rd_exp(5'(i + 2), (8'h5A ^ 8'(i)) & CTRL_MASK[i]);
        host.write_reg(ADDR_LINE_CONDITION_0, 8'h00);
        for (int k = 0; k < 6; k++)
            rd_exp(ADDR_LINE_CONDITION_0 + 5'(k), ST_EXP[k]);
    endtask

    task automatic t_standard();
        host.write_reg(ADDR_GLOBAL_CONFIG, 8'h05);
        chk(line_std, 1'b1, "T1 selected");
        chk(settling, 1'b1, "settle open");
        chk(config_bank[0], 8'h05, "global config");
        tick(SETTLE + 2);
        chk(settling, 1'b0, "settle closed");
    endtask

    task automatic t_soft();
        logic [7:0] d;
        logic       v;
        host.write_reg(ADDR_SOFT_RESET_TRIGGER, 8'hFF);
        tick(1);
        chk(in_reset, 1'b1, "soft reset in force");
        host.read_reg(ADDR_GLOBAL_CONFIG, d, v);
        chk({7'h00, v}, 8'h00, "read refused");
        chk(config_bank[0], 8'h04, "bank reset");
        wait_release();
        chk(line_std, 1'b1, "standard kept");
        rd_exp(ADDR_GLOBAL_CONFIG, 8'h04);
        rd_exp(ADDR_TRANSMIT_CONFIG_1, 8'h10);
        rd_exp(ADDR_JITTER_ATTEN_CONFIG, 8'h20);
        chk(drive_en, 1'b0, "drivers off");
    endtask

    // A short pulse is filtered, a long one resets.
    task automatic t_pin();
        host.write_reg(ADDR_TRANSMIT_CONFIG_1, 8'h00);
        tick(2);
        chk(drive_en, 1'b1, "drivers on");
        pin_n = 1'b0;
        tick(5);
        pin_n = 1'b1;
        tick(20);
        chk(in_reset, 1'b0, "short pulse ignored");
        pin_n = 1'b0;
        tick(20);
        chk(in_reset, 1'b1, "pin reset");
        chk(line_std, 1'b0, "standard cleared");
        chk(drive_en, 1'b0, "drivers off");
        pin_n = 1'b1;
        wait_release();
        rd_exp(ADDR_TRANSMIT_CONFIG_1, 8'h10);
    endtask

    task automatic wrap_up();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        tick(3);
        rst = 1'b0;
        t_defaults();
        t_map();
        t_standard();
        t_soft();
        t_pin();
        wrap_up();
    end

    // Watchdog far beyond the run's few hundred cycles.
    initial
    begin
        #50000;
        failures++;
        wrap_up();
    end
endmodule

// ### inc/liu_reg_pkg.sv
// Register map, reset timing and carrier types of the reset and register block.
package liu_reg_pkg;

    // Timing figures with derived cycle counts.
    localparam int CLK_PERIOD_NS       = 10;
    localparam int HW_RESET_MIN_NS     = 100;
    localparam int HW_RESET_MIN_CYCLES =
        (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_RESET_LIMIT_NS = 1000;
    localparam int SOFT_RESET_LIMIT_CYCLES =
        SOFT_RESET_LIMIT_NS / CLK_PERIOD_NS;
    localparam int SOFT_RESET_HOLD_CYCLES  = 8;
    localparam int SETTLE_US           = 50;
    localparam int SETTLE_CYCLES       = SETTLE_US * 1000 / CLK_PERIOD_NS;

    // Bus widths of the host port.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [4:0] ADDR_SILICON_REVISION       = 5'h00;
    localparam logic [4:0] ADDR_SOFT_RESET_TRIGGER     = 5'h01;
    localparam logic [4:0] ADDR_GLOBAL_CONFIG          = 5'h02;
    localparam logic [4:0] ADDR_LINE_IMPEDANCE_SELECT  = 5'h03;
    localparam logic [4:0] ADDR_JITTER_ATTEN_CONFIG    = 5'h04;
    localparam logic [4:0] ADDR_TRANSMIT_CONFIG_0      = 5'h05;
    localparam logic [4:0] ADDR_TRANSMIT_CONFIG_1      = 5'h06;
    localparam logic [4:0] ADDR_TRANSMIT_CONFIG_2      = 5'h07;
    localparam logic [4:0] ADDR_TRANSMIT_CONFIG_3      = 5'h08;
    localparam logic [4:0] ADDR_TRANSMIT_CONFIG_4      = 5'h09;
    localparam logic [4:0] ADDR_RECEIVE_CONFIG_0       = 5'h0A;
    localparam logic [4:0] ADDR_RECEIVE_CONFIG_1       = 5'h0B;
    localparam logic [4:0] ADDR_RECEIVE_CONFIG_2       = 5'h0C;
    localparam logic [4:0] ADDR_DIAG_PATTERN_CONTROL   = 5'h0D;
    localparam logic [4:0] ADDR_LOOPBACK_CONTROL       = 5'h0E;
    localparam logic [4:0] ADDR_INBAND_CODE_LENGTH     = 5'h0F;
    localparam logic [4:0] ADDR_TX_INBAND_CODE         = 5'h10;
    localparam logic [4:0] ADDR_RX_ACTIVATE_CODE       = 5'h11;
    localparam logic [4:0] ADDR_RX_DEACTIVATE_CODE     = 5'h12;
    localparam logic [4:0] ADDR_ERROR_INSERT_COUNT_CTRL = 5'h13;
    localparam logic [4:0] ADDR_IRQ_MASK_0             = 5'h14;
    localparam logic [4:0] ADDR_IRQ_MASK_1             = 5'h15;
    localparam logic [4:0] ADDR_IRQ_EDGE_SELECT        = 5'h16;
    localparam logic [4:0] ADDR_LINE_CONDITION_0       = 5'h17;
    localparam logic [4:0] ADDR_LINE_CONDITION_1       = 5'h18;
    localparam logic [4:0] ADDR_IRQ_FLAGS_0            = 5'h19;
    localparam logic [4:0] ADDR_IRQ_FLAGS_1            = 5'h1A;
    localparam logic [4:0] ADDR_ERROR_COUNT_LOW        = 5'h1B;
    localparam logic [4:0] ADDR_ERROR_COUNT_HIGH       = 5'h1C;

    // Control bank: global_config to irq_edge_select.
    localparam int CTRL_COUNT = 21;

    // Control bank indices and bit positions.
    localparam int IDX_GLOBAL_CONFIG    = 0;
    localparam int IDX_TRANSMIT_CONFIG_0 = 3;
    localparam int IDX_TRANSMIT_CONFIG_1 = 4;
    localparam int LINE_STANDARD_BIT    = 2;
    localparam int TX_POWER_DOWN_BIT    = 4;
    localparam int TX_HIGH_Z_BIT        = 4;
    localparam logic LINE_STANDARD_RESET = 1'b0;

    // Writable bits per register; the line-standard bit is kept apart.
    localparam logic [7:0] CTRL_MASK [0:CTRL_COUNT-1] = '{
        8'h03, 8'h3F, 8'h3F, 8'h1F, 8'h3F, 8'h3F, 8'hFF, 8'h7F,
        8'h1F, 8'h5F, 8'h33, 8'h7F, 8'h0F, 8'h3F, 8'hFF, 8'hFF,
        8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'h7F};

    // Default value of each control register.
    localparam logic [7:0] CTRL_RESET [0:CTRL_COUNT-1] = '{
        8'h00, 8'h00, 8'h20, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // One host access.
    typedef struct packed {
        logic        write;
        logic        read;
        logic [4:0]  addr;
        logic [7:0]  data;
    } host_req_type;

    // Status words from the line logic.
    typedef struct packed {
        logic [7:0]  line_condition_0;
        logic [7:0]  line_condition_1;
        logic [7:0]  irq_flags_0;
        logic [7:0]  irq_flags_1;
        logic [15:0] error_count;
    } line_status_type;

    // Whole control bank.
    typedef logic [CTRL_COUNT-1:0][7:0] ctrl_bank_type;

    // Reset sequencer states.
    typedef enum logic [1:0] {
        SEQ_RUN,
        SEQ_SOFT_RESET,
        SEQ_HW_RESET
    } reset_state_type;

endpackage

// ### rtl/reset_and_register_map.sv
// Reset handling and host register map of the line interface unit.
`timescale 1ns/100ps

// What this block does
// - Writing soft reset location resets within 1 us.
// - Reset pin low 100 ns resets device.
// - Line drivers high impedance after any reset.
// - All internal flip-flops set to reset values by i_reset.
// - All registers load defaults on pin or power-on reset.
// - Soft reset restores all port states but the line standard.
// - Soft reset keeps line-standard select bit.
// - Soft reset register write-only, holds nothing.
// - Address zero returns fixed silicon revision.
// - Map groups control, status, counter registers.
// - Line standard zero E1, one T1/J1.
module reset_and_register_map
    import liu_reg_pkg::*;
#(
    parameter int         SETTLE_COUNT     = SETTLE_CYCLES,
    parameter logic [7:0] SILICON_REVISION = 8'hA5  // Arbitrary value.
)
(
    input  wire logic            i_ref_clk,        // Master clock, 100 MHz.
    input  wire logic            i_reset,          // Async reset, high.
    input  wire logic            i_hw_reset_n,     // Reset pin, low active.
    input  wire host_req_type    i_host,           // Host access strobes.
    input  wire line_status_type i_status,         // Line status words.
    output logic [7:0]           o_rd_data,        // Read answer byte.
    output logic                 o_rd_valid,       // Read answer pulse.
    output ctrl_bank_type        o_config,         // Control bank contents.
    output logic                 o_line_standard,  // 0 = E1, 1 = T1/J1.
    output logic                 o_settling,       // Clocking settle window.
    output logic                 o_line_drive_en,  // Line driver enable.
    output logic                 o_in_reset        // Device held in reset.
);

    localparam int SET_W = $clog2(SETTLE_COUNT + 1);
    localparam logic [SET_W-1:0] SETTLE_LOAD = SET_W'(SETTLE_COUNT);

    // True inside the control bank.
    function automatic logic is_ctrl(input logic [4:0] addr);
        is_ctrl = (addr >= ADDR_GLOBAL_CONFIG) &&
                  (addr <= ADDR_IRQ_EDGE_SELECT);
    endfunction

    // Index of a control-bank address.
    function automatic logic [4:0] ctrl_index(input logic [4:0] addr);
        ctrl_index = addr - ADDR_GLOBAL_CONFIG;
    endfunction

    ctrl_bank_type       ctrl;
    logic                line_std;
    logic                soft_trigger;
    logic [SET_W-1:0]    settle_count;
    logic [SET_W-1:0]    next_settle_count;
    logic [7:0]          next_rd_data;
    wire logic           hw_reset;
    wire logic           any_reset;
    wire logic           host_open;
    wire logic           wr_take;
    wire logic           rd_take;
    wire logic           wr_soft;
    wire logic           wr_ctrl;
    wire logic [4:0]     wr_index;
    wire logic           wr_gcf;
    wire logic           next_line_std;
    wire logic           std_changes;
    wire logic           next_drive_en;
    wire logic [7:0]     gcf_view;

    // Pin filter and soft reset stretcher.
    reset_sequencer u_sequencer
    (
        .i_ref_clk      (i_ref_clk),
        .i_reset        (i_reset),
        .i_hw_reset_n   (i_hw_reset_n),
        .i_soft_trigger (soft_trigger),
        .o_hw_reset     (hw_reset),
        .o_any_reset    (any_reset)
    );

    // Accesses are dropped in reset and in the trigger's launch cycle.
    assign host_open = !any_reset && !soft_trigger;
    assign wr_take   = host_open && i_host.write;
    assign rd_take   = host_open && i_host.read && !i_host.write;

    // Write decode.
    assign wr_soft  = wr_take && (i_host.addr == ADDR_SOFT_RESET_TRIGGER);
    assign wr_ctrl  = wr_take && is_ctrl(i_host.addr);
    assign wr_index = ctrl_index(i_host.addr);
    assign wr_gcf   = wr_take && (i_host.addr == ADDR_GLOBAL_CONFIG);

    // Any write to the trigger fires it; the byte is never kept.
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
            soft_trigger <= 1'b0;
        else
            soft_trigger <= wr_soft;
    end

    // Control bank: defaults under any reset, else masked host writes.
    generate
        for (genvar i = 0; i < CTRL_COUNT; i++)
        begin : g_ctrl
            wire logic hit;
            assign hit = wr_ctrl && (wr_index == 5'(i));
            always_ff @(posedge i_ref_clk or posedge i_reset)
            begin
                if (i_reset)
                    ctrl[i] <= CTRL_RESET[i];
                else if (any_reset)
                    ctrl[i] <= CTRL_RESET[i];
                else if (hit)
                    ctrl[i] <= i_host.data & CTRL_MASK[i];
            end
        end
    endgenerate

    // Line standard survives a soft reset only.
    assign next_line_std = hw_reset ? LINE_STANDARD_RESET :
                           wr_gcf ? i_host.data[LINE_STANDARD_BIT] :
                           line_std;
    assign std_changes = (next_line_std != line_std);

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
            line_std <= LINE_STANDARD_RESET;
        else
            line_std <= next_line_std;
    end

    // The settle window is only reported; accesses are not refused.
    assign next_settle_count = any_reset ? '0 :
                               std_changes ? SETTLE_LOAD :
                               (settle_count != '0) ?
                               settle_count - SET_W'(1) : settle_count;

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            settle_count <= '0;
            o_settling   <= 1'b0;
        end
        else
        begin
            settle_count <= next_settle_count;
            o_settling   <= (next_settle_count != '0);
        end
    end

    // Drivers stay off in reset; the high-Z default keeps them off after.
    assign next_drive_en = !any_reset && !soft_trigger &&
        !ctrl[IDX_TRANSMIT_CONFIG_0][TX_POWER_DOWN_BIT] &&
        !ctrl[IDX_TRANSMIT_CONFIG_1][TX_HIGH_Z_BIT];

    // Global config read view with the held line-standard bit.
    assign gcf_view = ctrl[IDX_GLOBAL_CONFIG] |
                      (8'(line_std) << LINE_STANDARD_BIT);

    // Read multiplexer over control, status and counter groups.
    always_comb
    begin
        next_rd_data = 8'h00;
        if (is_ctrl(i_host.addr))
        begin
            if (i_host.addr == ADDR_GLOBAL_CONFIG)
                next_rd_data = gcf_view;
            else
                next_rd_data = ctrl[ctrl_index(i_host.addr)];
        end
        else
        begin
            case (i_host.addr)
                ADDR_SILICON_REVISION:
                    next_rd_data = SILICON_REVISION;
                ADDR_LINE_CONDITION_0:
                    next_rd_data = i_status.line_condition_0 & 8'h7F;
                ADDR_LINE_CONDITION_1:
                    next_rd_data = i_status.line_condition_1 & 8'h20;
                ADDR_IRQ_FLAGS_0:
                    next_rd_data = i_status.irq_flags_0 & 8'h7F;
                ADDR_IRQ_FLAGS_1:
                    next_rd_data = i_status.irq_flags_1;
                ADDR_ERROR_COUNT_LOW:
                    next_rd_data = i_status.error_count[7:0];
                ADDR_ERROR_COUNT_HIGH:
                    next_rd_data = i_status.error_count[15:8];
                default:
                    next_rd_data = 8'h00;
            endcase
        end
    end

    // Read answer and port states; a soft reset returns all but the line standard.
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_rd_data       <= 8'h00;
            o_rd_valid      <= 1'b0;
            o_line_drive_en <= 1'b0;
            o_in_reset      <= 1'b0;
            o_line_standard <= LINE_STANDARD_RESET;
        end
        else if (any_reset)
        begin
            o_rd_data       <= 8'h00;
            o_rd_valid      <= 1'b0;
            o_line_drive_en <= 1'b0;
            o_in_reset      <= 1'b1;
            o_line_standard <= next_line_std;
        end
        else
        begin
            o_rd_data       <= rd_take ? next_rd_data : o_rd_data;
            o_rd_valid      <= rd_take;
            o_line_drive_en <= next_drive_en;
            o_in_reset      <= 1'b0;
            o_line_standard <= next_line_std;
        end
    end

    // The bank leaves from its flops, line-standard bit merged in.
    always_comb
    begin
        o_config = ctrl;
        o_config[IDX_GLOBAL_CONFIG] = gcf_view;
    end

endmodule

// ### rtl/reset_sequencer.sv
// Hardware reset pin filter and software reset stretcher.
`timescale 1ns/100ps
module reset_sequencer
    import liu_reg_pkg::*;
(
    input  wire logic i_ref_clk,       // Master clock.
    input  wire logic i_reset,         // Asynchronous power-on reset.
    input  wire logic i_hw_reset_n,    // Reset pin, active low, async.
    input  wire logic i_soft_trigger,  // One-cycle software reset request.
    output logic      o_hw_reset,      // Hardware reset in force.
    output logic      o_any_reset      // Either reset in force.
);

    localparam int LOW_W  = $clog2(HW_RESET_MIN_CYCLES + 1);
    localparam int HOLD_W = $clog2(SOFT_RESET_HOLD_CYCLES + 1);
    localparam logic [LOW_W-1:0] LOW_FULL =
        LOW_W'(HW_RESET_MIN_CYCLES);
    localparam logic [HOLD_W-1:0] HOLD_LAST =
        HOLD_W'(SOFT_RESET_HOLD_CYCLES - 1);

    logic                  pin_meta;
    logic                  pin_sync;
    logic [LOW_W-1:0]      low_count;
    logic [LOW_W-1:0]      next_low_count;
    logic [HOLD_W-1:0]     hold_count;
    logic [HOLD_W-1:0]     next_hold_count;
    reset_state_type       state;
    reset_state_type       next_state;
    wire logic             pin_held;

    // The pin is asynchronous: two flops before any logic.
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            pin_meta <= i_hw_reset_n;
            pin_sync <= pin_meta;
        end
    end

    // Low time is counted so short glitches never reset.
    assign next_low_count = pin_sync ? '0 :
                            (low_count == LOW_FULL) ? low_count :
                            low_count + LOW_W'(1);
    assign pin_held = (low_count == LOW_FULL);

    // A pin reset wins over a soft reset in progress.
    always_comb
    begin
        next_state      = state;
        next_hold_count = hold_count;
        case (state)
            SEQ_RUN:
            begin
                if (pin_held)
                    next_state = SEQ_HW_RESET;
                else if (i_soft_trigger)
                begin
                    next_state      = SEQ_SOFT_RESET;
                    next_hold_count = '0;
                end
            end
            SEQ_SOFT_RESET:
            begin
                next_hold_count = hold_count + HOLD_W'(1);
                if (pin_held)
                    next_state = SEQ_HW_RESET;
                else if (hold_count == HOLD_LAST)
                    next_state = SEQ_RUN;
            end
            SEQ_HW_RESET:
            begin
                if (pin_sync)
                    next_state = SEQ_RUN;
            end
            default:
                next_state = SEQ_RUN;
        endcase
    end

    // Outputs registered from the next state.
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            low_count   <= '0;
            hold_count  <= '0;
            state       <= SEQ_RUN;
            o_hw_reset  <= 1'b0;
            o_any_reset <= 1'b0;
        end
        else
        begin
            low_count   <= next_low_count;
            hold_count  <= next_hold_count;
            state       <= next_state;
            o_hw_reset  <= (next_state == SEQ_HW_RESET);
            o_any_reset <= (next_state != SEQ_RUN);
        end
    end

endmodule
